// File: common/amcr_pkg.sv
`default_nettype none

// shared constants and types of the converter mode control bank
package amcr_pkg;

	// widths of the programming word and of the sample path
	localparam int REG_W       = 8;
	localparam int ADDR_W      = 7;
	localparam int FRAME_BITS  = 16;
	localparam int CNT_W       = 5;
	localparam int SAMPLE_W    = 14;
	localparam int SLEEP_CNT_W = 6;

	// register addresses
	localparam logic [ADDR_W-1:0] ADDR_SOFT_RESET    = 7'h00;
	localparam logic [ADDR_W-1:0] ADDR_POWER_DOWN    = 7'h01;
	localparam logic [ADDR_W-1:0] ADDR_DRIVER_MODE   = 7'h02;
	localparam logic [ADDR_W-1:0] ADDR_PATTERN_UPPER = 7'h03;
	localparam logic [ADDR_W-1:0] ADDR_PATTERN_LOWER = 7'h04;

	// reset value of every register
	localparam logic [REG_W-1:0] REG_RESET = 8'h00;

	// field positions
	localparam int BIT_SOFT_RESET = 7;
	localparam int BIT_DCS_OFF    = 7;
	localparam int BIT_SCRAMBLE   = 6;
	localparam int BIT_SIGNED     = 5;
	localparam int BIT_SLEEP      = 4;
	localparam int BIT_NAP_2      = 3;
	localparam int BIT_NAP_1      = 0;
	localparam int CUR_HI         = 7;
	localparam int CUR_LO         = 5;
	localparam int BIT_TERM       = 4;
	localparam int BIT_OUT_OFF    = 3;
	localparam int SER_HI         = 2;
	localparam int SER_LO         = 0;
	localparam int BIT_PAT_EN     = 7;
	localparam int PAT_UP_HI      = 5;

	// driver current codes
	localparam logic [2:0] CUR_4P0 = 3'h1;
	localparam logic [2:0] CUR_4P5 = 3'h2;
	localparam logic [2:0] CUR_3P0 = 3'h4;
	localparam logic [2:0] CUR_2P5 = 3'h5;
	localparam logic [2:0] CUR_2P1 = 3'h6;

	// serialization codes
	localparam logic [2:0] SER_2L16 = 3'h0;
	localparam logic [2:0] SER_2L14 = 3'h1;
	localparam logic [2:0] SER_2L12 = 3'h2;
	localparam logic [2:0] SER_1L14 = 3'h5;
	localparam logic [2:0] SER_1L16 = 3'h6;

	// serial bit counter landmarks
	localparam logic [CNT_W-1:0] CNT_ADDR_DONE  = 5'h07;
	localparam logic [CNT_W-1:0] CNT_DATA_FIRST = 5'h08;
	localparam logic [CNT_W-1:0] CNT_LAST       = 5'h0f;
	localparam logic [CNT_W-1:0] CNT_FRAME      = 5'h10;
	localparam logic [CNT_W-1:0] CNT_STEP       = 5'h01;

	// sleep hold during soft reset, time then cycles rounded up
	localparam int CLK_PERIOD_PS  = 25000;
	localparam int SOFT_SLEEP_NS  = 1000;
	localparam int SOFT_SLEEP_CYC = (SOFT_SLEEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [SLEEP_CNT_W-1:0] SLEEP_CNT_INIT = SLEEP_CNT_W'(SOFT_SLEEP_CYC - 1);
	localparam logic [SLEEP_CNT_W-1:0] SLEEP_CNT_STEP = 6'h01;
	localparam logic [SLEEP_CNT_W-1:0] SLEEP_CNT_ZERO = 6'h00;

	// one programming word, first bit on the wire is rw
	typedef struct packed {
		logic              rw;
		logic [ADDR_W-1:0] addr;
		logic [REG_W-1:0]  data;
	} amcr_frame_t;

	// the four readable registers
	typedef struct packed {
		logic [REG_W-1:0] pattern_lower;
		logic [REG_W-1:0] pattern_upper;
		logic [REG_W-1:0] driver_mode;
		logic [REG_W-1:0] power_down;
	} amcr_bank_t;

	localparam amcr_bank_t BANK_RESET = {4{REG_RESET}};

	// control sequencer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_WRITE = 3'b010,
		ST_SLEEP = 3'b100
	} amcr_state_t;

endpackage

`default_nettype wire

// File: verilog/amcr_sync.sv
`default_nettype none

// three-stage level synchroniser; output moves only when stages two and three agree
module amcr_sync (
	input  wire logic clock,    // destination clock
	input  wire logic sys_rst,  // async reset, active high
	input  wire logic async_in, // level from another domain
	output logic      sync_out  // settled level
);
	logic stage1; // only ever read by stage2
	logic stage2; // second stage
	logic stage3; // third stage

	// shift chain, constants under reset
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// agreement filter, rejects a single late resolve
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sync_out <= 1'b0;
		end else if (stage2 == stage3) begin
			sync_out <= stage3;
		end
	end
endmodule

`default_nettype wire

// File: verilog/amcr_serial_port.sv
`default_nettype none

// serial programming port, runs on the host's serial clock
module amcr_serial_port
	import amcr_pkg::*;
(
	input  wire logic       sys_rst,   // async reset, active high
	input  wire logic       cs_n,      // frame select, active low
	input  wire logic       sck,       // serial clock from host
	input  wire logic       sdi,       // serial data in
	input  wire amcr_bank_t rd_bank,   // register contents for readback
	output var amcr_frame_t wr_frame,  // last complete write word
	output logic            wr_toggle, // flips once per write word
	output logic            sdo_out,   // open-drain data level, always low
	output logic            sdo_oe     // high while pulling the line low
);
	logic [CNT_W-1:0]      bit_cnt;   // rising edges seen in this frame
	logic [FRAME_BITS-2:0] shift_in;  // bits captured so far
	logic [REG_W-1:0]      rd_byte;   // byte being read back
	logic                  rd_active; // frame is a read
	logic [ADDR_W-1:0]     rd_addr;   // address as it completes
	logic [REG_W-1:0]      rd_sel;    // register picked by rd_addr
	logic                  frame_rst; // frame ends or system reset

	// sck stops between frames, so the frame's own select ends it
	assign frame_rst = cs_n | sys_rst;
	assign rd_addr   = {shift_in[ADDR_W-2:0], sdi};

	// edges after the sixteenth are ignored
	always_ff @(posedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			bit_cnt  <= '0;
			shift_in <= '0;
		end else if (bit_cnt < CNT_FRAME) begin // R14
			shift_in <= {shift_in[FRAME_BITS-3:0], sdi};
			bit_cnt  <= bit_cnt + CNT_STEP;
		end
	end

	// publish a write word; a read word is never published
	always_ff @(posedge sck or posedge sys_rst) begin
		if (sys_rst) begin
			wr_frame  <= '0;
			wr_toggle <= 1'b0;
		end else if (bit_cnt == CNT_LAST && !shift_in[FRAME_BITS-2]) begin // R14
			wr_frame  <= {shift_in, sdi};
			wr_toggle <= ~wr_toggle;
		end
	end

	// readback mux; reset register is write only and reads zero
	always_comb begin
		unique case (rd_addr)
			ADDR_POWER_DOWN:    rd_sel = rd_bank.power_down;
			ADDR_DRIVER_MODE:   rd_sel = rd_bank.driver_mode;
			ADDR_PATTERN_UPPER: rd_sel = rd_bank.pattern_upper;
			ADDR_PATTERN_LOWER: rd_sel = rd_bank.pattern_lower;
			default:            rd_sel = REG_RESET; // R5
		endcase
	end

	// bank is quasi-static: it only moves after a write word crossed over
	always_ff @(posedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			rd_byte   <= REG_RESET;
			rd_active <= 1'b0;
		end else if (bit_cnt == CNT_ADDR_DONE) begin
			rd_active <= shift_in[ADDR_W-1];
			rd_byte   <= rd_sel;
		end
	end

	// data msb first on falling edges, pull low for a zero
	always_ff @(negedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			sdo_oe <= 1'b0;
		end else begin
			sdo_oe <= rd_active && (bit_cnt >= CNT_DATA_FIRST) && (bit_cnt < CNT_FRAME)
				&& !rd_byte[~bit_cnt[2:0]];
		end
	end

	// open-drain level, never driven high
	always_ff @(posedge sck or posedge sys_rst) begin
		if (sys_rst) begin
			sdo_out <= 1'b0;
		end else begin
			sdo_out <= 1'b0;
		end
	end
endmodule

`default_nettype wire

// File: verilog/amcr_mode_regs.sv
`default_nettype none

// Overview of operation
// R1 - host programs registers soon after power-up
// R2 - host's first serial command is soft reset
// R3 - reset bit write clears all registers
// R4 - reset bit clears itself after write
// R5 - reset register write only, low bits ignored
// R6 - soft reset briefly forces sleep
// R7 - power-down bit 7 disables duty stabilizer
// R8 - output bits 7..5 select driver current
// R9 - termination doubles driver current
// R10 - output bits 2..0 select serialization
// R11 - pattern upper bit 7 enables pattern
// R12 - upper bits 5..0 give data 13..8
// R13 - lower bits give data 7..0
// R14 - sixteen bit word, reads change nothing
// R15 - scrambler xors lsb into other bits
// R16 - drive disable turns off all outputs
// R17 - pattern overrides signed format and scrambler
// R18 - power-down bit 5 selects signed coding
// R19 - unmapped addresses change nothing
module amcr_mode_regs
	import amcr_pkg::*;
(
	input  wire logic                clock,                       // system clock
	input  wire logic                sys_rst,                     // async reset, active high
	input  wire logic                cs_n,                        // serial frame select, active low
	input  wire logic                sck,                         // serial clock from host
	input  wire logic                sdi,                         // serial data in
	output logic                     sdo_out,                     // open-drain data level
	output logic                     sdo_oe,                      // open-drain pull enable
	input  wire logic [SAMPLE_W-1:0] raw_sample,                  // offset binary from the core
	output logic [SAMPLE_W-1:0]      out_data,                    // formatted sample to serializer
	output logic                     data_drive_enable,           // data, clock, frame drivers on
	output logic                     output_drive_disable,        // drive disable bit
	output logic                     duty_stabilizer_disable,     // stabilizer off
	output logic                     output_scramble_enable,      // scrambler on
	output logic                     signed_format_select,        // two's complement coding
	output logic                     sleep_mode,                  // whole converter asleep
	output logic                     nap_ch1,                     // channel 1 napping
	output logic                     nap_ch2,                     // channel 2 napping
	output logic [2:0]               driver_current_select,       // driver current code
	output logic                     driver_current_legal,        // code is a listed current
	output logic                     internal_termination_enable, // on-chip termination
	output logic                     drive_current_double,        // current is twice the code
	output logic [2:0]               serialization_select,        // lane and width code
	output logic                     serialization_legal,         // code is a listed mode
	output logic                     fixed_pattern_enable,        // test pattern replaces data
	output logic [PAT_UP_HI:0]       pattern_upper_bits,          // pattern bits 13..8
	output logic [REG_W-1:0]         pattern_lower_bits           // pattern bits 7..0
);
	amcr_frame_t                wr_frame;       // word from the link, held stable
	logic                       wr_toggle;      // link event, toggled per write
	logic                       tog_sync;       // event level in this domain
	logic                       tog_seen;       // last event level consumed
	logic                       frame_pending;  // a write word waits
	logic                       soft_reset_hit; // reset bit written this cycle
	logic                       write_hit;      // mapped write this cycle
	amcr_state_t                state;          // sequencer state
	amcr_state_t                next_state;     // sequencer next state
	amcr_bank_t                 bank;           // the registers themselves
	logic [SLEEP_CNT_W-1:0]     sleep_cnt;      // cycles of sleep left
	logic [SAMPLE_W-1:0]        next_data;      // formatted sample, before the flop

	// address lies inside the register map
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return a <= ADDR_PATTERN_LOWER;
	endfunction

	// driver current code names a real current
	function automatic logic current_legal(input logic [2:0] c);
		logic ok;
		ok = 1'b0;
		case (c)
			CUR_4P0, CUR_4P5, CUR_3P0, CUR_2P5, CUR_2P1: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// serialization code names a real mode
	function automatic logic serial_legal(input logic [2:0] c);
		logic ok;
		ok = 1'b0;
		case (c)
			SER_2L16, SER_2L14, SER_2L12, SER_1L14, SER_1L16: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// link side: shifts words in on sck, reads back on sdo
	amcr_serial_port u_port (
		.sys_rst   (sys_rst),
		.cs_n      (cs_n),
		.sck       (sck),
		.sdi       (sdi),
		.rd_bank   (bank),
		.wr_frame  (wr_frame),
		.wr_toggle (wr_toggle),
		.sdo_out   (sdo_out),
		.sdo_oe    (sdo_oe)
	);

	// event crosses as a level; the word stays put until the next frame
	amcr_sync u_sync (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.async_in (wr_toggle),
		.sync_out (tog_sync)
	);

	assign frame_pending = tog_sync ^ tog_seen;

	// decode of the word being applied
	assign soft_reset_hit = (state == ST_WRITE) && !wr_frame.rw
		&& (wr_frame.addr == ADDR_SOFT_RESET) && wr_frame.data[BIT_SOFT_RESET]; // R3
	assign write_hit = (state == ST_WRITE) && !wr_frame.rw && is_mapped(wr_frame.addr); // R14 R19

	// sequencer: wait, apply one word, optionally hold sleep
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (frame_pending) begin
					next_state = ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (soft_reset_hit) begin
					next_state = ST_SLEEP; // R6
				end else begin
					next_state = ST_IDLE;
				end
			end
			ST_SLEEP: begin
				if (sleep_cnt == SLEEP_CNT_ZERO) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE; // broken one-hot code recovers
			end
		endcase
	end

	// state register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// mark the word consumed; a word arriving in sleep waits its turn
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			tog_seen <= 1'b0;
		end else if (state == ST_WRITE) begin
			tog_seen <= ~tog_seen;
		end
	end

	// sleep hold counter, loaded by the reset write
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sleep_cnt <= SLEEP_CNT_ZERO;
		end else if (soft_reset_hit) begin
			sleep_cnt <= SLEEP_CNT_INIT; // R6
		end else if (sleep_cnt != SLEEP_CNT_ZERO) begin
			sleep_cnt <= sleep_cnt - SLEEP_CNT_STEP;
		end
	end

	// register bank; the reset bit itself is never stored, so it reads back clear
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			bank <= BANK_RESET;
		end else if (soft_reset_hit) begin
			bank <= BANK_RESET; // R3 R4
		end else if (write_hit) begin
			case (wr_frame.addr)
				ADDR_POWER_DOWN:    bank.power_down    <= wr_frame.data;
				ADDR_DRIVER_MODE:   bank.driver_mode   <= wr_frame.data;
				ADDR_PATTERN_UPPER: bank.pattern_upper <= wr_frame.data;
				ADDR_PATTERN_LOWER: bank.pattern_lower <= wr_frame.data;
				default: ; // reset register with bit 7 low: bits 6..0 ignored (R5)
			endcase
		end
	end

	// power-down field outputs
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			duty_stabilizer_disable <= 1'b0;
			output_scramble_enable  <= 1'b0;
			signed_format_select    <= 1'b0;
			sleep_mode              <= 1'b0;
			nap_ch1                 <= 1'b0;
			nap_ch2                 <= 1'b0;
		end else begin
			duty_stabilizer_disable <= bank.power_down[BIT_DCS_OFF]; // R7
			output_scramble_enable  <= bank.power_down[BIT_SCRAMBLE];
			signed_format_select    <= bank.power_down[BIT_SIGNED];
			sleep_mode              <= bank.power_down[BIT_SLEEP] | (state == ST_SLEEP); // R6
			nap_ch1                 <= bank.power_down[BIT_NAP_1];
			nap_ch2                 <= bank.power_down[BIT_NAP_2];
		end
	end

	// driver and serialization outputs
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			driver_current_select       <= 3'h0;
			driver_current_legal        <= 1'b0;
			internal_termination_enable <= 1'b0;
			drive_current_double        <= 1'b0;
			output_drive_disable        <= 1'b0;
			data_drive_enable           <= 1'b0;
			serialization_select        <= 3'h0;
			serialization_legal         <= 1'b0;
		end else begin
			driver_current_select       <= bank.driver_mode[CUR_HI:CUR_LO]; // R8
			driver_current_legal        <= current_legal(bank.driver_mode[CUR_HI:CUR_LO]); // R8
			internal_termination_enable <= bank.driver_mode[BIT_TERM];
			drive_current_double        <= bank.driver_mode[BIT_TERM]; // R9
			output_drive_disable        <= bank.driver_mode[BIT_OUT_OFF];
			data_drive_enable           <= ~bank.driver_mode[BIT_OUT_OFF]; // R16
			serialization_select        <= bank.driver_mode[SER_HI:SER_LO]; // R10
			serialization_legal         <= serial_legal(bank.driver_mode[SER_HI:SER_LO]); // R10
		end
	end

	// pattern outputs
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fixed_pattern_enable <= 1'b0;
			pattern_upper_bits   <= '0;
			pattern_lower_bits   <= REG_RESET;
		end else begin
			fixed_pattern_enable <= bank.pattern_upper[BIT_PAT_EN]; // R11
			pattern_upper_bits   <= bank.pattern_upper[PAT_UP_HI:0]; // R12
			pattern_lower_bits   <= bank.pattern_lower; // R13
		end
	end

	// formatting: coding first, then scrambling; the pattern beats both
	always_comb begin
		next_data = raw_sample;
		if (bank.power_down[BIT_SIGNED]) begin
			next_data[SAMPLE_W-1] = ~raw_sample[SAMPLE_W-1]; // R18
		end
		if (bank.power_down[BIT_SCRAMBLE]) begin
			next_data[SAMPLE_W-1:1] = next_data[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){next_data[0]}}; // R15
		end
		if (bank.pattern_upper[BIT_PAT_EN]) begin
			next_data = {bank.pattern_upper[PAT_UP_HI:0], bank.pattern_lower}; // R17 R12 R13
		end
	end

	// sample register toward the serializer
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			out_data <= '0;
		end else begin
			out_data <= next_data;
		end
	end

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	// reset write empties the bank on the next edge
	property p_soft_reset_clears;
		soft_reset_hit |=> (bank == BANK_RESET);
	endproperty
	a_soft_reset_clears: assert property (p_soft_reset_clears) else $error("soft reset left data"); // R3

	// sequence finishes and the bank is left clear, ready for the next word
	property p_reset_self_clears;
		soft_reset_hit |=> (state == ST_SLEEP)[*8] ##33 (state == ST_IDLE) && (bank == BANK_RESET);
	endproperty
	a_reset_self_clears: assert property (p_reset_self_clears) else $error("reset sequence did not end"); // R4

	// reset register with bit 7 low changes nothing
	property p_reset_low_bits_ignored;
		(state == ST_WRITE) && !wr_frame.rw && (wr_frame.addr == ADDR_SOFT_RESET)
			&& !wr_frame.data[BIT_SOFT_RESET] |=> $stable(bank);
	endproperty
	a_reset_low_bits_ignored: assert property (p_reset_low_bits_ignored) else $error("reset low bits acted"); // R5

	// sleep forced while the reset sequence holds
	property p_reset_sleeps;
		soft_reset_hit |=> ##1 sleep_mode [*8];
	endproperty
	a_reset_sleeps: assert property (p_reset_sleeps) else $error("no sleep during soft reset"); // R6

	// stabilizer output follows its bit
	property p_stabilizer;
		##1 (duty_stabilizer_disable == $past(bank.power_down[BIT_DCS_OFF]));
	endproperty
	a_stabilizer: assert property (p_stabilizer) else $error("stabilizer bit not followed"); // R7

	// termination doubles the current
	property p_double_current;
		bank.driver_mode[BIT_TERM] |=> drive_current_double && internal_termination_enable;
	endproperty
	a_double_current: assert property (p_double_current) else $error("current not doubled"); // R9

	// unlisted serialization codes 3 and 4 flagged
	property p_serial_code;
		(bank.driver_mode[SER_HI:SER_LO] == 3'h3) || (bank.driver_mode[SER_HI:SER_LO] == 3'h4)
			|=> !serialization_legal;
	endproperty
	a_serial_code: assert property (p_serial_code) else $error("unused serialization code accepted"); // R10

	// enabled pattern reaches the data, overriding the format bits
	property p_pattern_wins;
		bank.pattern_upper[BIT_PAT_EN] |=> fixed_pattern_enable
			&& (out_data == $past({bank.pattern_upper[PAT_UP_HI:0], bank.pattern_lower}));
	endproperty
	a_pattern_wins: assert property (p_pattern_wins) else $error("pattern not on outputs"); // R17

	// scrambler alone: lsb folded into the upper bits
	property p_scramble;
		bank.power_down[BIT_SCRAMBLE] && !bank.power_down[BIT_SIGNED] && !bank.pattern_upper[BIT_PAT_EN]
			|=> (out_data == ($past(raw_sample) ^ {{(SAMPLE_W-1){$past(raw_sample[0])}}, 1'b0}));
	endproperty
	a_scramble: assert property (p_scramble) else $error("scrambled data wrong"); // R15

	// drive disable shuts the drivers off
	property p_drive_off;
		bank.driver_mode[BIT_OUT_OFF] |=> !data_drive_enable;
	endproperty
	a_drive_off: assert property (p_drive_off) else $error("drivers still on"); // R16

	// signed coding flips the msb only
	property p_signed;
		bank.power_down[BIT_SIGNED] && !bank.power_down[BIT_SCRAMBLE] && !bank.pattern_upper[BIT_PAT_EN]
			|=> (out_data == ($past(raw_sample) ^ {1'b1, {(SAMPLE_W-1){1'b0}}}));
	endproperty
	a_signed: assert property (p_signed) else $error("signed coding wrong"); // R18

	// unmapped writes leave the bank alone
	property p_unmapped;
		(state == ST_WRITE) && !is_mapped(wr_frame.addr) |=> $stable(bank);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped write changed a register"); // R19

	// main scenarios
	c_soft_reset: cover property (soft_reset_hit);
	c_pattern_on: cover property (write_hit && (wr_frame.addr == ADDR_PATTERN_UPPER) && wr_frame.data[BIT_PAT_EN]);
	c_scramble_on: cover property (output_scramble_enable && signed_format_select);
	c_unmapped: cover property ((state == ST_WRITE) && !is_mapped(wr_frame.addr));
endmodule

`default_nettype wire

// File: tb/amcr_host.sv
`default_nettype none

// host side of the programming port; sck idles low outside frames
module amcr_host
	import amcr_pkg::*;
(
	output logic      cs_n, // frame select
	output logic      sck,  // 12 ns serial clock
	output logic      sdi,  // serial data
	input  wire logic sdo   // resolved open-drain line
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		sdi  = 1'b0;
	end
	// one word msb first; readback taken on rises 9..16
	task automatic xfer(input amcr_frame_t f, output logic [REG_W-1:0] rd);
		cs_n = 1'b0;
		#6;
		for (int i = FRAME_BITS - 1; i >= 0; i--) begin
			sdi = f[i];
			#6 sck = 1'b1;
			if (i < REG_W) rd[i] = sdo;
			#6 sck = 1'b0;
		end
		#6 cs_n = 1'b1;
		sdi = ~sdi; // released line must not echo the last bit
		#12; // select stays high between frames, so a back-to-back call still ends this one
	endtask
endmodule

`default_nettype wire

// File: tb/testbench.sv
`default_nettype none

module testbench
	import amcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                clock       = 1'b0;
	logic                sys_rst     = 1'b1;
	logic [SAMPLE_W-1:0] raw_sample  = 14'h0000;
	logic [31:0]         x           = 32'h8a71;   // xorshift state
	logic [7:0]          r [5]       = '{default: 8'h00}; // bench copy of the bank
	logic [7:0]          rd;                       // last readback
	logic [47:0]         q [$];                    // notes; bit 47 marks readback
	logic [47:0]         e, g;
	int                  checks      = 0;
	int                  miscompares = 0;
	event                chk;
	wire logic           cs_n, sck, sdi, sdo_out, sdo_oe, sdo;
	wire logic [46:0]    o;                        // all status outputs, one vector
	assign sdo = sdo_oe ? sdo_out : 1'b1;           // pull-up when nobody pulls
	always #12.5 clock = ~clock;
	amcr_host u_host (.cs_n, .sck, .sdi, .sdo);
	amcr_mode_regs u_dut (
		.clock, .sys_rst, .cs_n, .sck, .sdi, .sdo_out, .sdo_oe, .raw_sample, .out_data(o[13:0]),
		.data_drive_enable(o[14]), .output_drive_disable(o[15]), .duty_stabilizer_disable(o[46]),
		.output_scramble_enable(o[45]), .signed_format_select(o[44]), .sleep_mode(o[43]),
		.nap_ch1(o[42]), .nap_ch2(o[41]), .driver_current_select(o[40:38]), .driver_current_legal(o[37]),
		.internal_termination_enable(o[36]), .drive_current_double(o[35]), .serialization_select(o[34:32]),
		.serialization_legal(o[31]), .fixed_pattern_enable(o[30]), .pattern_upper_bits(o[29:24]),
		.pattern_lower_bits(o[23:16])
	);
	function automatic logic [31:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// expected status; pattern wins over coding and scrambler
	function automatic logic [46:0] ev(input logic s);
		logic [SAMPLE_W-1:0] c;
		logic [7:0]          cm, sm;
		cm = 8'h76; // listed current codes
		sm = 8'h67; // listed serialization codes
		c = raw_sample ^ {r[1][5], 13'h0000};
		if (r[1][6]) c = c ^ {{13{c[0]}}, 1'b0};
		if (r[3][7]) c = {r[3][5:0], r[4]};
		return {r[1][7:5], r[1][4] | s, r[1][0], r[1][3], r[2][7:5], cm[r[2][7:5]], r[2][4], r[2][4],
			r[2][2:0], sm[r[2][2:0]], r[3][7], r[3][5:0], r[4], r[2][3], ~r[2][3], c};
	endfunction
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		u_host.xfer({1'b0, a, d}, rd);
		if (a inside {[1:4]}) r[a] = d;
		if (a == 7'h00 && d[7]) r = '{default: 8'h00};
		repeat (12) @(posedge clock); // room for the sync and apply
	endtask
	task automatic ck(input logic s);
		@(posedge clock) raw_sample <= SAMPLE_W'(rnd());
		repeat (2) @(posedge clock);
		#1 q.push_back({1'b0, ev(s)});
		->chk;
	endtask
	task automatic rb(input logic [6:0] a);
		u_host.xfer({1'b1, a, 8'h00}, rd);
		q.push_back({1'b1, 39'h0, (a inside {[1:4]}) ? r[a] : 8'h00});
		->chk;
	endtask
	// soft reset: sleep held a while, then the status outputs show the cleared bank
	task automatic sr(input logic [7:0] d);
		wr(7'h00, d);
		ck(1'b1);
		repeat (45) @(posedge clock);
		ck(1'b0);
	endtask
	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// result watcher, oldest note first
	initial forever begin
		@(chk);
		e = q.pop_front();
		g = e[47] ? {1'b1, 39'h0, rd} : {1'b0, o};
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", e[47] ? "readback" : "status", e, g);
		end
	end
	initial begin
		repeat (5000) @(posedge clock);
		miscompares++; // hang
		report_and_stop;
	end
	initial begin
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clock);
		sr(8'h80);
		for (int i = 0; i < 8; i++) begin
			wr(7'h02, {3'(i), 2'(rnd()), 3'(i)});
			ck(1'b0);
			rb(7'h02);
		end
		for (int i = 0; i < 4; i++) begin
			wr(7'h01, 8'(rnd()));
			ck(1'b0);
			rb(7'h01);
		end
		wr(7'h03, 8'h80 | 8'(rnd()));
		wr(7'h04, 8'(rnd()));
		ck(1'b0);
		rb(7'h03);
		wr(7'h03, 8'h7f & 8'(rnd()));
		ck(1'b0);
		wr(7'h05 + 7'(rnd() % 32'h7b), 8'(rnd()));
		ck(1'b0);
		wr(7'h00, 8'h7f & 8'(rnd()));
		ck(1'b0);
		rb(7'h00);
		sr(8'h80 | 8'(rnd()));
		rb(7'h01);
		repeat (2) @(posedge clock);
		report_and_stop;
	end
endmodule

`default_nettype wire
